// *** core/e1_rx_backplane_sync_rate.sv ***
// Summary of operation
// - fifo mode: direction bit 1 input, 0 output
// - output sync one bit, frame's last, active low if sync_low above 2.048
// - input sync pulse realigns outgoing frame
// - multiframe sync at last bit, frame one
// - control bit 2 selects channel multiplexing
// - mode bits with mux bit pick rate
// - non-mux codes: legacy, mvip, 4.096, 8.192
// - mux codes: none, bitmux, hmvip, h100 16.384
// - non-mux channel uses its own pins
// - mvip rates: clock, data, sync inputs
// - mvip rates: multiframe sync stays output
// - slip enable code 10 selects fifo mode
// - data launched rising, sampled falling edge
`timescale 1ns/100ps
`default_nettype none

module e1_rx_backplane_sync_rate (
	// system
	input wire logic clk_in,
	input wire logic rst_b_in,
	// axi4-lite write
	input wire logic [e1_rx_bp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// axi4-lite read
	input wire logic [e1_rx_bp_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// received payload from the framer
	input wire e1_rx_bp_pkg::payload_write_type payload_write_in,
	input wire logic payload_valid_in,
	// back-plane link of this channel
	input wire logic rx_backplane_clock_in,
	input wire logic rx_frame_sync_in,
	output logic rx_frame_sync_out,
	output logic rx_frame_sync_oe_out,
	input wire logic rx_backplane_serial_data_in,
	output logic rx_backplane_serial_data_out,
	output logic rx_backplane_serial_data_oe_out,
	output logic rx_multiframe_sync_out
);
	import e1_rx_bp_pkg::*;

	// ****************************************
	// register bus
	// ****************************************
	logic [7:0] fifo_depth;
	logic [7:0] rx_if_ctrl;
	logic [7:0] sb_ctrl;
	logic [7:0] frame_count;
	logic aw_held;
	logic w_held;
	logic [5:0] aw_index;
	logic [7:0] w_byte;
	logic w_lane0;

	function automatic logic is_mapped(input logic [5:0] idx);
		return idx == FIFO_DEPTH_INDEX || idx == RX_IF_CTRL_INDEX ||
			idx == SB_CTRL_INDEX || idx == STATUS_INDEX;
	endfunction

	logic aw_take;
	logic w_take;
	logic do_write;
	logic [5:0] wr_index;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic [5:0] ar_index;
	logic [31:0] rd_word;
	logic depth_wr;
	logic ctrl_wr;
	logic sb_wr;
	assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
	assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
	assign w_take = s_axi_wvalid_in && s_axi_wready_out;
	assign wr_index = aw_held ? aw_index : s_axi_awaddr_in[7:2];
	assign wr_byte = w_held ? w_byte : s_axi_wdata_in[7:0];
	assign wr_lane = w_held ? w_lane0 : s_axi_wstrb_in[0];
	assign do_write = (aw_held || aw_take) && (w_held || w_take) &&
		!s_axi_bvalid_out;
	assign depth_wr = do_write && wr_lane && wr_index == FIFO_DEPTH_INDEX;
	assign ctrl_wr = do_write && wr_lane && wr_index == RX_IF_CTRL_INDEX;
	assign sb_wr = do_write && wr_lane && wr_index == SB_CTRL_INDEX;
	assign ar_index = s_axi_araddr_in[7:2];

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_index <= 6'h00;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end else begin
			aw_held <= (aw_held || aw_take) && !do_write;
			w_held <= (w_held || w_take) && !do_write;
			aw_index <= wr_index;
			w_byte <= wr_byte;
			w_lane0 <= wr_lane;
			if (do_write) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= is_mapped(wr_index) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			fifo_depth <= FIFO_DEPTH_RESET;
			rx_if_ctrl <= RX_IF_CTRL_RESET;
			sb_ctrl <= SB_CTRL_RESET;
		end else begin
			fifo_depth <= depth_wr ? wr_byte : fifo_depth;
			rx_if_ctrl <= ctrl_wr ? wr_byte : rx_if_ctrl;
			sb_ctrl <= sb_wr ? wr_byte : sb_ctrl;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= is_mapped(ar_index) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// ****************************************
	// mode decode and pin directions
	// ****************************************
	logic mux_on;
	logic [1:0] mode;
	logic fifo_mode;
	logic mvip_rate;
	logic sync_input;
	link_cfg_type cfg_c;
	assign mux_on = rx_if_ctrl[MUX_BIT];
	assign mode = rx_if_ctrl[MODE_LSB +: 2];
	assign fifo_mode = sb_ctrl[SB_EN_LSB +: 2] == SB_EN_FIFO;
	assign mvip_rate = !mux_on && mode != MODE_LEGACY;
	// direction bit only counts in fifo mode, else the rate decides
	assign sync_input = fifo_mode ? sb_ctrl[SB_DIR_BIT] : mvip_rate;
	assign cfg_c = '{sync_low: rx_if_ctrl[SYNC_LOW_BIT], mux: mux_on,
		mode: mode, fifo_mode: fifo_mode, sync_input: sync_input,
		depth: fifo_depth[DEPTH_W-1:0]};
	assign rd_word = ar_index == FIFO_DEPTH_INDEX ? {24'h000000, fifo_depth} :
		ar_index == RX_IF_CTRL_INDEX ? {24'h000000, rx_if_ctrl} :
		ar_index == SB_CTRL_INDEX ? {24'h000000, sb_ctrl} :
		ar_index == STATUS_INDEX ? {22'h0,
		rx_backplane_serial_data_oe_out, sync_input, frame_count} :
		32'h0000_0000;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rx_frame_sync_oe_out <= 1'b0;
			rx_backplane_serial_data_oe_out <= 1'b0;
		end else begin
			rx_frame_sync_oe_out <= !sync_input;
			rx_backplane_serial_data_oe_out <= !mvip_rate;
		end
	end

	// ****************************************
	// link domain
	// ****************************************
	// config is quasi-static: software changes it only while the link idles
	logic rst_l1;
	logic link_rst_b;
	link_cfg_type cfg_l1;
	link_cfg_type cfg_l;
	logic sync_s1;
	logic sync_s2;
	logic sync_s3;
	logic [CNT_W-1:0] cnt;
	logic [3:0] frame_num;
	logic frame_tgl;

	always_ff @(posedge rx_backplane_clock_in) begin
		rst_l1 <= rst_b_in;
		link_rst_b <= rst_l1;
		cfg_l1 <= cfg_c;
		cfg_l <= cfg_l1;
		sync_s1 <= rx_frame_sync_in;
		sync_s2 <= sync_s1;
		sync_s3 <= sync_s2;
	end

	logic [1:0] shift_l;
	logic pol_l;
	logic align_hit;
	logic wrap;
	logic [CNT_W-1:0] next_cnt;
	logic [7:0] cur_bit;
	logic [7:0] nxt_bit;
	logic [4:0] rd_addr;
	logic [7:0] rd_data;
	logic rd_bit;
	logic idle_l;
	assign shift_l = rate_shift(cfg_l.mux, cfg_l.mode);
	// active-low sync only applies above the 2.048 rate
	assign pol_l = cfg_l.sync_low && (cfg_l.mux || cfg_l.mode[1]);
	assign align_hit = cfg_l.sync_input && (sync_s2 ^ pol_l) &&
		!(sync_s3 ^ pol_l);
	assign wrap = cnt == frame_last(shift_l);
	assign next_cnt = align_hit ? SYNC_ALIGN :
		wrap ? '0 : cnt + CNT_W'(1);
	assign cur_bit = e1_bit(cnt, shift_l);
	assign nxt_bit = e1_bit(next_cnt, shift_l);
	// fifo latency: read trails the write slot by the programmed depth
	assign rd_addr = nxt_bit[7:3] - (cfg_l.fifo_mode ? cfg_l.depth : 5'h00);
	assign rd_bit = rd_data[3'h7 - cur_bit[2:0]];
	assign idle_l = cfg_l.mux && cfg_l.mode == MODE_LEGACY;

	e1_rx_frame_store store (
		.wr_clk_in(clk_in),
		.wr_en_in(payload_valid_in),
		.wr_addr_in(payload_write_in.slot),
		.wr_data_in(payload_write_in.data),
		.rd_clk_in(rx_backplane_clock_in),
		.rd_addr_in(rd_addr),
		.rd_data_out(rd_data)
	);

	// each channel drives only its own pins in this slice
	always_ff @(posedge rx_backplane_clock_in) begin
		if (!link_rst_b) begin
			cnt <= '0;
			frame_num <= 4'h0;
			frame_tgl <= 1'b0;
			rx_frame_sync_out <= 1'b0;
			rx_multiframe_sync_out <= 1'b0;
			rx_backplane_serial_data_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			frame_num <= frame_num + ((wrap && !align_hit) ? 4'h1 : 4'h0);
			frame_tgl <= frame_tgl ^ (wrap && !align_hit);
			rx_frame_sync_out <= (cur_bit == LAST_BIT) ^ pol_l;
			rx_multiframe_sync_out <= cur_bit == LAST_BIT &&
				frame_num == MF_SYNC_FRAME;
			rx_backplane_serial_data_out <= !idle_l && rd_bit;
		end
	end

	// ****************************************
	// frame count back to the bus domain
	// ****************************************
	logic tgl_s1;
	logic tgl_s2;
	logic tgl_s3;
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
			frame_count <= 8'h00;
		end else begin
			tgl_s1 <= frame_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
			frame_count <= frame_count + ((tgl_s2 ^ tgl_s3) ? 8'h01 : 8'h00);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sync_dir_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		fifo_mode |=> rx_frame_sync_oe_out == !$past(sb_ctrl[SB_DIR_BIT]))
		else $error("sync direction does not follow control bit");
	mvip_pins_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!fifo_mode && mvip_rate |=> !rx_frame_sync_oe_out &&
		!rx_backplane_serial_data_oe_out)
		else $error("mvip rate pins not inputs");
	mux_bit_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		ctrl_wr |=> mux_on == $past(wr_byte[MUX_BIT]))
		else $error("multiplex enable not taken from bit 2");
	fifo_code_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		sb_wr && wr_byte[1:0] == SB_EN_FIFO |=> fifo_mode)
		else $error("fifo mode not entered on code 10");
	sync_pos_a: assert property (@(posedge rx_backplane_clock_in)
		disable iff (!link_rst_b)
		!pol_l && $rose(rx_frame_sync_out) && shift_l == SHIFT_2048 &&
		!align_hit |-> $past(cur_bit) == LAST_BIT ##1 !rx_frame_sync_out)
		else $error("frame sync not one bit at last position");
	mf_pos_a: assert property (@(posedge rx_backplane_clock_in)
		disable iff (!link_rst_b)
		rx_multiframe_sync_out |-> $past(frame_num) == MF_SYNC_FRAME &&
		$past(cur_bit) == LAST_BIT)
		else $error("multiframe sync outside frame one last bit");
	align_a: assert property (@(posedge rx_backplane_clock_in)
		disable iff (!link_rst_b)
		align_hit |=> cnt == SYNC_ALIGN)
		else $error("input sync did not realign the frame");
	rate_sel_a: assert property (@(posedge rx_backplane_clock_in)
		disable iff (!link_rst_b)
		!cfg_l.mux && cfg_l.mode == MODE_8192 |-> shift_l == SHIFT_8192 &&
		frame_last(shift_l) == 11'h3ff)
		else $error("8.192 rate frame length wrong");
	mux_rate_a: assert property (@(posedge rx_backplane_clock_in)
		disable iff (!link_rst_b)
		cfg_l.mux |-> shift_l == SHIFT_MUX)
		else $error("multiplexed rate not 16.384");
	data_idle_a: assert property (@(posedge rx_backplane_clock_in)
		disable iff (!link_rst_b)
		idle_l |=> !rx_backplane_serial_data_out)
		else $error("data not idle in unassigned mode");
	data_launch_a: assert property (@(posedge rx_backplane_clock_in)
		disable iff (!link_rst_b)
		!idle_l |=> rx_backplane_serial_data_out == $past(rd_bit))
		else $error("data not launched from current bit");
endmodule

`default_nettype wire

// *** core/e1_rx_bp_pkg.sv ***
package e1_rx_bp_pkg;

	// ****************************************
	// register map (index; byte address = 4 * index)
	// ****************************************
	localparam int AXI_ADDR_W = 8;
	localparam logic [5:0] FIFO_DEPTH_INDEX = 6'h17;
	localparam logic [5:0] RX_IF_CTRL_INDEX = 6'h22;
	localparam logic [5:0] SB_CTRL_INDEX = 6'h30;
	localparam logic [5:0] STATUS_INDEX = 6'h31;
	localparam logic [7:0] FIFO_DEPTH_RESET = 8'h04;
	localparam logic [7:0] RX_IF_CTRL_RESET = 8'h00;
	localparam logic [7:0] SB_CTRL_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// fields
	// ****************************************
	localparam int MODE_LSB = 0;
	localparam int MUX_BIT = 2;
	localparam int SYNC_LOW_BIT = 3;
	localparam int SB_EN_LSB = 0;
	localparam int SB_DIR_BIT = 2;
	localparam int DEPTH_W = 5;
	localparam logic [1:0] SB_EN_FIFO = 2'h2;
	localparam logic [1:0] MODE_LEGACY = 2'h0;
	localparam logic [1:0] MODE_MVIP = 2'h1;
	localparam logic [1:0] MODE_4096 = 2'h2;
	localparam logic [1:0] MODE_8192 = 2'h3;
	localparam logic [1:0] SHIFT_2048 = 2'h0;
	localparam logic [1:0] SHIFT_4096 = 2'h1;
	localparam logic [1:0] SHIFT_8192 = 2'h2;
	localparam logic [1:0] SHIFT_MUX = 2'h3;

	// ****************************************
	// e1 framing and timing
	// ****************************************
	localparam int E1_BIT_NS = 488;
	localparam int LINK_2048_NS = 488;
	localparam int E1_BIT_CYCLES = E1_BIT_NS / LINK_2048_NS;
	localparam int E1_BITS = 256;
	localparam int CNT_W = 11;
	localparam logic [7:0] LAST_BIT = 8'hff;
	localparam logic [3:0] MF_SYNC_FRAME = 4'h1;
	localparam logic [CNT_W-1:0] SYNC_ALIGN = 11'h004;

	typedef struct packed {
		logic sync_low;
		logic mux;
		logic [1:0] mode;
		logic fifo_mode;
		logic sync_input;
		logic [DEPTH_W-1:0] depth;
	} link_cfg_type;

	typedef struct packed {
		logic [4:0] slot;
		logic [7:0] data;
	} payload_write_type;

	function automatic logic [1:0] rate_shift(input logic mux,
		input logic [1:0] mode);
		logic [1:0] sh;
		sh = SHIFT_2048;
		if (mux) begin
			sh = SHIFT_MUX;
		end else if (mode == MODE_4096) begin
			sh = SHIFT_4096;
		end else if (mode == MODE_8192) begin
			sh = SHIFT_8192;
		end
		return sh;
	endfunction

	function automatic logic [7:0] e1_bit(input logic [CNT_W-1:0] cnt,
		input logic [1:0] sh);
		logic [CNT_W-1:0] t;
		t = cnt >> sh;
		return t[7:0];
	endfunction

	// 256 << 3 wraps to zero in 11 bits, so the minus one gives 2047
	function automatic logic [CNT_W-1:0] frame_last(input logic [1:0] sh);
		logic [CNT_W-1:0] len;
		len = CNT_W'(E1_BITS * E1_BIT_CYCLES) << sh;
		return len - CNT_W'(1);
	endfunction

endpackage

// *** core/e1_rx_frame_store.sv ***
`timescale 1ns/100ps
`default_nettype none

// one e1 frame of payload bytes, written by the framer, read at the link
module e1_rx_frame_store (
	// write side
	input wire logic wr_clk_in,
	input wire logic wr_en_in,
	input wire logic [4:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	// read side
	input wire logic rd_clk_in,
	input wire logic [4:0] rd_addr_in,
	output logic [7:0] rd_data_out
);
	logic [7:0] mem [0:31];

	always_ff @(posedge wr_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge rd_clk_in) begin
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

`default_nettype wire

// *** verif/e1_rx_backplane_sync_rate_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module e1_rx_backplane_sync_rate_bench;
	import e1_rx_bp_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	payload_write_type pw = '0;
	logic pvalid = 1'b0;
	logic link_clk, te_sync, sync_out, sync_oe, data_out, data_oe, mf;
	logic drive_sync = 1'b0;
	logic [7:0] frame [32];
	logic [7:0] exp_b [32];
	int period, pulses, mf_at;
	int n_mismatch = 0;
	int checked = 0;
	logic [31:0] seed = 32'h5f;
	logic [1:0] resp;
	logic [31:0] rd;
	logic [4:0] depth;
	wire sync_wire = sync_oe ? sync_out : te_sync;
	// a released data line shows a changing level, not the last bit
	wire data_wire = data_oe ? data_out : ~data_out;

	always #2 clk_in = ~clk_in;

	e1_rx_backplane_sync_rate uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .payload_write_in(pw),
		.payload_valid_in(pvalid), .rx_backplane_clock_in(link_clk),
		.rx_frame_sync_in(sync_wire), .rx_frame_sync_out(sync_out),
		.rx_frame_sync_oe_out(sync_oe),
		.rx_backplane_serial_data_in(data_wire),
		.rx_backplane_serial_data_out(data_out),
		.rx_backplane_serial_data_oe_out(data_oe),
		.rx_multiframe_sync_out(mf));

	e1_rx_term_equip te (.drive_sync_in(drive_sync), .link_clk_out(link_clk),
		.sync_drive_out(te_sync), .sync_wire_in(sync_wire),
		.data_wire_in(data_wire), .mf_in(mf), .frame_out(frame),
		.period_out(period), .pulses_out(pulses), .mf_at_out(mf_at));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			n_mismatch++;
			$display("Error wait ran out");
			give_verdict();
		end
	endtask

	// handshakes are judged mid-cycle, where nothing moves before the edge
	task automatic axi_wr(input logic [5:0] idx, input logic [7:0] d);
		int n;
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge clk_in);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !tb; n++) begin
			@(negedge clk_in);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			resp = bresp;
			@(posedge clk_in);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		bound(n, 50);
	endtask

	task automatic axi_rd(input logic [5:0] idx);
		int n;
		logic ta, tr;
		tr = 1'b0;
		@(posedge clk_in);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !tr; n++) begin
			@(negedge clk_in);
			ta = arvalid && arready;
			tr = rvalid;
			rd = rdata;
			resp = rresp;
			@(posedge clk_in);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		bound(n, 50);
	endtask

	task automatic wait_pulses(input int k);
		int n, t;
		t = pulses + k;
		for (n = 0; n < 300 * k && pulses < t; n++) begin
			@(negedge link_clk);
			#1;
		end
		bound(n, 300 * k);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (8) @(posedge clk_in);
		// link reset needs three of its own edges as well
		repeat (4) @(posedge link_clk);
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		axi_rd(FIFO_DEPTH_INDEX);
		check("depth reset", rd, 32'(FIFO_DEPTH_RESET));
		axi_rd(RX_IF_CTRL_INDEX);
		check("control reset", rd, 32'(RX_IF_CTRL_RESET));
		axi_wr(6'h3c, 8'h5a);
		check("unmapped bresp", resp, RESP_SLVERR);
		for (int s = 0; s < 32; s++) begin
			seed = xs(seed);
			exp_b[s] = seed[7:0];
			@(posedge clk_in);
			pw <= '{slot: 5'(s), data: seed[7:0]};
			pvalid <= 1'b1;
			@(posedge clk_in);
			pvalid <= 1'b0;
		end
		$display("registers and payload loaded");
		wait_pulses(3);
		check("sync oe", sync_oe, 1'b1);
		check("sync period", period, 256);
		check("multiframe pulse", mf_at, 2);
		for (int s = 0; s < 32; s++) begin
			check("byte", frame[s], exp_b[s]);
		end
		axi_rd(STATUS_INDEX);
		check("status rresp", resp, RESP_OKAY);
		check("status dir", rd[9:8], 2'h2);
		check("frames sent", rd[7:0] != 8'h00, 1'b1);
		$display("output sync frame done");
		for (int m = 0; m < 8; m++) begin
			axi_wr(RX_IF_CTRL_INDEX, 8'(m));
			axi_rd(RX_IF_CTRL_INDEX);
			check("control", rd, 32'(m));
			repeat (12) @(posedge clk_in);
			if (m > 3) begin
				check("mux data oe", data_oe, 1'b1);
			end else begin
				check("data oe", data_oe, m == 0);
				check("sync in", sync_oe, m == 0);
			end
		end
		axi_wr(RX_IF_CTRL_INDEX, 8'h04);
		// config needs two link flops and an output edge to arrive
		repeat (200) @(posedge clk_in);
		for (int c = 0; c < 3000; c++) begin
			@(negedge clk_in);
			if (c % 100 == 0) check("idle data", data_out, 1'b0);
		end
		$display("rate modes done");
		axi_wr(RX_IF_CTRL_INDEX, 8'h00);
		seed = xs(seed);
		depth = seed[4:0];
		axi_wr(FIFO_DEPTH_INDEX, 8'(depth));
		axi_wr(SB_CTRL_INDEX, 8'h06);
		repeat (12) @(posedge clk_in);
		check("sync input", sync_oe, 1'b0);
		drive_sync <= 1'b1;
		// first pulse may beat the config crossing, so allow a spare frame
		wait_pulses(4);
		for (int s = 0; s < 32; s++) begin
			check("fifo byte", frame[s], exp_b[5'(s - depth)]);
		end
		drive_sync <= 1'b0;
		axi_wr(SB_CTRL_INDEX, 8'h02);
		repeat (12) @(posedge clk_in);
		check("sync output", sync_oe, 1'b1);
		$display("fifo input sync done");
		give_verdict();
	end
endmodule

`default_nettype wire

// *** verif/e1_rx_term_equip.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// terminal equipment on the back-plane
// ****************************************
module e1_rx_term_equip (
	// from the bench
	input wire logic drive_sync_in,
	// link pins
	output logic link_clk_out,
	output logic sync_drive_out,
	input wire logic sync_wire_in,
	input wire logic data_wire_in,
	input wire logic mf_in,
	// what was seen
	output logic [7:0] frame_out [32],
	output int period_out,
	output int pulses_out,
	output int mf_at_out
);
	int ph = 0;
	int since = 0;
	int bit_i = 256;
	logic [7:0] acc [32];

	initial begin
		link_clk_out = 1'b0;
		sync_drive_out = 1'b0;
		period_out = 0;
		pulses_out = 0;
		mf_at_out = 0;
		// odd phase keeps link edges off the system clock edges
		#13.3;
		// timing source runs free, with a 160 ns period
		forever #80 link_clk_out = ~link_clk_out;
	end

	// one-bit pulse on the framing bit
	always @(posedge link_clk_out) begin
		ph <= (ph == 255) ? 0 : ph + 1;
		sync_drive_out <= drive_sync_in && ph == 255;
	end

	// sampled on the falling edge
	// an output sync closes the frame
	// a driven sync marks bit 0 of the frame itself
	always @(negedge link_clk_out) begin
		since++;
		if (sync_wire_in === 1'b1 && drive_sync_in) begin
			bit_i = 0;
		end
		if (bit_i < 256) begin
			acc[bit_i / 8] = {acc[bit_i / 8][6:0], data_wire_in};
			bit_i++;
			if (bit_i == 256) begin
				frame_out = acc;
			end
		end
		if (sync_wire_in === 1'b1) begin
			period_out = since;
			since = 0;
			pulses_out++;
			if (!drive_sync_in) begin
				bit_i = 0;
			end
			if (mf_in === 1'b1 && mf_at_out == 0) begin
				mf_at_out = pulses_out;
			end
		end else if (mf_in === 1'b1 && !drive_sync_in) begin
			mf_at_out = 99;
		end
	end
endmodule

`default_nettype wire
